/* src/fcs_defs.vh */
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// reserved, IGMP and MLD multicast prefixes and the broadcast destination address
`define FCS_RSV_PREFIX 40'h0180C20000
`define FCS_BCAST_DA 48'hFFFFFFFFFFFF
`define FCS_IGMP_PREFIX 24'h01005E
`define FCS_MLD_PREFIX 16'h3333

// last address byte values and range bounds
`define FCS_LB_BPDU 8'h00
`define FCS_LB_PAUSE 8'h01
`define FCS_LB_SLOW 8'h02
`define FCS_LB_PAE 8'h03
`define FCS_LB_R0_LO 8'h04
`define FCS_LB_R0_HI 8'h0F
`define FCS_LB_R1_LO 8'h10
`define FCS_LB_R1_HI 8'h1F
`define FCS_LB_GARP_LO 8'h20
`define FCS_LB_GARP_HI 8'h22
`define FCS_LB_R2_LO 8'h23
`define FCS_LB_R2_HI 8'h2F
`define FCS_LB_R3_LO 8'h30
`define FCS_LB_R3_HI 8'hFF

// ether-types, opcodes, versions, protocols
`define FCS_ET_NON_PAUSE_CONTROL_FRAME 16'h8808
`define FCS_OP_PAUSE 16'h0001
`define FCS_ET_RARP 16'h8035
`define FCS_ET_ARP 16'h8036
`define FCS_ET_IPV4 16'h0800
`define FCS_ET_IPV6 16'h86DD
`define FCS_IPVER_4 4'h4
`define FCS_IPVER_6 4'h6
`define FCS_PROTO_IGMP 8'h02
`define FCS_PROTO_ICMP6 8'h3A

// class codes
`define FCS_CLS_OTHER 4'h0
`define FCS_CLS_BPDU 4'h1
`define FCS_CLS_PAUSE 4'h2
`define FCS_CLS_SLOW 4'h3
`define FCS_CLS_PAE 4'h4
`define FCS_CLS_R0 4'h5
`define FCS_CLS_R1 4'h6
`define FCS_CLS_GARP 4'h7
`define FCS_CLS_R2 4'h8
`define FCS_CLS_R3 4'h9
`define FCS_CLS_RARP 4'hA
`define FCS_CLS_ARP 4'hB
`define FCS_CLS_IGMP4 4'hC
`define FCS_CLS_LISTENER_DISC_OVER_IP 4'hD
`define FCS_CLS_MLD_IP6 4'hE
`define FCS_CLS_NON_PAUSE_CONTROL_FRAME 4'hF

// address groups
`define FCS_GRP_UNICAST 2'h0
`define FCS_GRP_MULTICAST 2'h1
`define FCS_GRP_BROADCAST 2'h2

// spanning tree port states
`define FCS_STP_DISABLED 2'h0
`define FCS_STP_BLOCKING 2'h1
`define FCS_STP_LEARNING 2'h2
`define FCS_STP_FORWARDING 2'h3
`define FCS_STP_RST 2'h3

// port table
`define FCS_NUM_PORTS 6
`define FCS_PORT_W 3

`endif

/* src/fcs_stp_mem.v */
`timescale 1ns/1ps
`include "fcs_defs.vh"

module fcs_stp_mem (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire wr_en,
	input wire [`FCS_PORT_W-1:0] wr_port,
	input wire [1:0] wr_state,
	input wire [`FCS_PORT_W-1:0] rd_port,
	output wire [1:0] rd_state
);
	reg [1:0] state_ff [0:`FCS_NUM_PORTS-1];
	reg [1:0] rd_state_ff;
	integer i;

	assign rd_state = rd_state_ff;

	always @(posedge clk) begin
		if (!rstn) begin
			for (i = 0; i < `FCS_NUM_PORTS; i = i + 1) begin
				state_ff[i] <= `FCS_STP_RST;
			end
			rd_state_ff <= `FCS_STP_RST;
		end else if (ce) begin
			// port numbers past the table are ignored
			if (wr_en && wr_port < `FCS_NUM_PORTS) begin
				state_ff[wr_port] <= wr_state;
			end
			// unknown ports read as disabled so their frames never pass
			if (rd_port < `FCS_NUM_PORTS) begin
				rd_state_ff <= state_ff[rd_port];
			end else begin
				rd_state_ff <= `FCS_STP_DISABLED;
			end
		end
	end
endmodule // fcs_stp_mem

/* src/fcs_classifier.v */
`timescale 1ns/1ps
`include "fcs_defs.vh"

module fcs_classifier (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire hdr_valid,
	input wire [47:0] dest_addr,
	input wire [15:0] ether_type,
	input wire [15:0] ctrl_opcode,
	input wire [3:0] ip_version,
	input wire [7:0] ip_protocol,
	input wire [15:0] l4_port,
	input wire [`FCS_PORT_W-1:0] src_port,
	input wire tag_span_valid,
	input wire tag_span,
	input wire tag_mgmt_valid,
	input wire tag_mgmt,
	input wire learn_hit,
	input wire learn_span,
	input wire learn_mgmt,
	input wire ctrl_hit,
	input wire ctrl_span,
	input wire ctrl_mgmt,
	input wire cfg_rsv_span,
	input wire cfg_rsv_mgmt,
	input wire cfg_arp_span,
	input wire cfg_arp_mgmt,
	input wire cfg_igmp_span,
	input wire cfg_igmp_mgmt,
	input wire cfg_type_flt_en,
	input wire [15:0] cfg_type_flt,
	input wire cfg_proto_flt_en,
	input wire [7:0] cfg_proto_flt,
	input wire cfg_l4_flt_en,
	input wire [15:0] cfg_l4_flt,
	input wire stp_wr_en,
	input wire [`FCS_PORT_W-1:0] stp_wr_port,
	input wire [1:0] stp_wr_state,
	output wire res_valid,
	output wire [3:0] res_class,
	output wire [1:0] res_group,
	output wire res_type_match,
	output wire res_proto_match,
	output wire l4_port_filter_match,
	output wire res_span,
	output wire res_mgmt,
	output wire res_mgmt_exempt,
	output wire res_fwd_drop,
	output wire res_learn_en,
	output wire [1:0] res_port_state
);
	// stage one: classified fields
	reg s1_valid_ff;
	reg [3:0] s1_class_ff;
	reg [1:0] s1_group_ff;
	reg s1_type_ff;
	reg s1_proto_ff;
	reg s1_l4_ff;
	reg s1_tag_span_valid_ff;
	reg s1_tag_span_ff;
	reg s1_tag_mgmt_valid_ff;
	reg s1_tag_mgmt_ff;
	reg s1_learn_hit_ff;
	reg s1_learn_span_ff;
	reg s1_learn_mgmt_ff;
	reg s1_ctrl_hit_ff;
	reg s1_ctrl_span_ff;
	reg s1_ctrl_mgmt_ff;

	// stage two: results to forwarding
	reg res_valid_ff;
	reg [3:0] res_class_ff;
	reg [1:0] res_group_ff;
	reg res_type_ff;
	reg res_proto_ff;
	reg res_l4_ff;
	reg res_span_ff;
	reg res_mgmt_ff;
	reg res_exempt_ff;
	reg res_drop_ff;
	reg res_learn_ff;
	reg [1:0] res_state_ff;

	wire [1:0] port_state;
	wire [3:0] nxt_class;
	wire [1:0] nxt_group;
	reg nxt_span;
	reg nxt_mgmt;
	reg nxt_drop;
	reg nxt_learn;

	function [3:0] classify;
		input [47:0] da;
		input [15:0] et;
		input [15:0] op;
		input [3:0] ver;
		input [7:0] pr;
		reg [7:0] lb;
		reg rsv;
		begin
			lb = da[7:0];
			rsv = (da[47:8] == `FCS_RSV_PREFIX);
			classify = `FCS_CLS_OTHER;
			if (rsv && lb == `FCS_LB_BPDU) begin
				classify = `FCS_CLS_BPDU;
			end else if (rsv && lb == `FCS_LB_PAUSE &&
				et == `FCS_ET_NON_PAUSE_CONTROL_FRAME && op == `FCS_OP_PAUSE) begin
				classify = `FCS_CLS_PAUSE;
			end else if (rsv && lb == `FCS_LB_SLOW) begin
				classify = `FCS_CLS_SLOW;
			end else if (rsv && lb == `FCS_LB_PAE) begin
				classify = `FCS_CLS_PAE;
			end else if (rsv && lb >= `FCS_LB_R0_LO &&
				lb <= `FCS_LB_R0_HI) begin
				classify = `FCS_CLS_R0;
			end else if (rsv && lb >= `FCS_LB_R1_LO &&
				lb <= `FCS_LB_R1_HI) begin
				classify = `FCS_CLS_R1;
			end else if (rsv && lb >= `FCS_LB_GARP_LO &&
				lb <= `FCS_LB_GARP_HI) begin
				classify = `FCS_CLS_GARP;
			end else if (rsv && lb >= `FCS_LB_R2_LO &&
				lb <= `FCS_LB_R2_HI) begin
				classify = `FCS_CLS_R2;
			end else if (rsv && lb >= `FCS_LB_R3_LO &&
				lb <= `FCS_LB_R3_HI) begin
				classify = `FCS_CLS_R3;
			end else if (da == `FCS_BCAST_DA && et == `FCS_ET_RARP) begin
				classify = `FCS_CLS_RARP;
			end else if (da == `FCS_BCAST_DA && et == `FCS_ET_ARP) begin
				classify = `FCS_CLS_ARP;
			end else if (da[47:24] == `FCS_IGMP_PREFIX &&
				et == `FCS_ET_IPV4 && ver == `FCS_IPVER_4 &&
				pr == `FCS_PROTO_IGMP) begin
				classify = `FCS_CLS_IGMP4;
			end else if (da[47:32] == `FCS_MLD_PREFIX &&
				et == `FCS_ET_IPV4 && ver == `FCS_IPVER_6 &&
				pr == `FCS_PROTO_ICMP6) begin
				classify = `FCS_CLS_LISTENER_DISC_OVER_IP;
			end else if (da[47:32] == `FCS_MLD_PREFIX &&
				et == `FCS_ET_IPV6 && ver == `FCS_IPVER_6 &&
				pr == `FCS_PROTO_ICMP6) begin
				classify = `FCS_CLS_MLD_IP6;
			end else if (et == `FCS_ET_NON_PAUSE_CONTROL_FRAME && op != `FCS_OP_PAUSE) begin
				classify = `FCS_CLS_NON_PAUSE_CONTROL_FRAME;
			end
		end
	endfunction

	// shared by span and management resolution
	function resolve;
		input [3:0] cls;
		input tag_v;
		input tag_b;
		input lt_hit;
		input lt_b;
		input ct_hit;
		input ct_b;
		input rsv_b;
		input arp_b;
		input igmp_b;
		begin
			if (tag_v) begin
				resolve = tag_b;
			end else begin
				case (cls)
				`FCS_CLS_BPDU, `FCS_CLS_SLOW, `FCS_CLS_PAE,
				`FCS_CLS_R0, `FCS_CLS_R1, `FCS_CLS_GARP,
				`FCS_CLS_R2, `FCS_CLS_R3: begin
					resolve = lt_hit ? lt_b : (ct_hit ? ct_b : rsv_b);
				end
				`FCS_CLS_ARP, `FCS_CLS_RARP: begin
					resolve = arp_b;
				end
				`FCS_CLS_IGMP4, `FCS_CLS_LISTENER_DISC_OVER_IP, `FCS_CLS_MLD_IP6: begin
					resolve = igmp_b;
				end
				default: begin
					// pause and unmatched frames fall to the learning table
					resolve = lt_hit ? lt_b : 1'b0;
				end
				endcase
			end
		end
	endfunction

	function [1:0] group_of;
		input [47:0] da;
		begin
			// the first bit on the wire is bit 0 of the first octet
			if (da == `FCS_BCAST_DA) begin
				group_of = `FCS_GRP_BROADCAST;
			end else if (da[40]) begin
				group_of = `FCS_GRP_MULTICAST;
			end else begin
				group_of = `FCS_GRP_UNICAST;
			end
		end
	endfunction

	assign nxt_class = classify(dest_addr, ether_type, ctrl_opcode,
		ip_version, ip_protocol);
	assign nxt_group = group_of(dest_addr);

	// read issued with the header so state lands with stage one
	fcs_stp_mem u_stp_mem (
		.clk(clk),
		.rstn(rstn),
		.ce(ce),
		.wr_en(stp_wr_en),
		.wr_port(stp_wr_port),
		.wr_state(stp_wr_state),
		.rd_port(src_port),
		.rd_state(port_state)
	);

	always @(posedge clk) begin
		if (!rstn) begin
			s1_valid_ff <= 1'b0;
			s1_class_ff <= `FCS_CLS_OTHER;
			s1_group_ff <= `FCS_GRP_UNICAST;
			s1_type_ff <= 1'b0;
			s1_proto_ff <= 1'b0;
			s1_l4_ff <= 1'b0;
			s1_tag_span_valid_ff <= 1'b0;
			s1_tag_span_ff <= 1'b0;
			s1_tag_mgmt_valid_ff <= 1'b0;
			s1_tag_mgmt_ff <= 1'b0;
			s1_learn_hit_ff <= 1'b0;
			s1_learn_span_ff <= 1'b0;
			s1_learn_mgmt_ff <= 1'b0;
			s1_ctrl_hit_ff <= 1'b0;
			s1_ctrl_span_ff <= 1'b0;
			s1_ctrl_mgmt_ff <= 1'b0;
		end else if (ce) begin
			s1_valid_ff <= hdr_valid;
			if (hdr_valid) begin
				s1_class_ff <= nxt_class;
				s1_group_ff <= nxt_group;
				s1_type_ff <= cfg_type_flt_en &&
					ether_type == cfg_type_flt;
				s1_proto_ff <= cfg_proto_flt_en &&
					ip_protocol == cfg_proto_flt;
				s1_l4_ff <= cfg_l4_flt_en && l4_port == cfg_l4_flt;
				s1_tag_span_valid_ff <= tag_span_valid;
				s1_tag_span_ff <= tag_span;
				s1_tag_mgmt_valid_ff <= tag_mgmt_valid;
				s1_tag_mgmt_ff <= tag_mgmt;
				s1_learn_hit_ff <= learn_hit;
				s1_learn_span_ff <= learn_span;
				s1_learn_mgmt_ff <= learn_mgmt;
				s1_ctrl_hit_ff <= ctrl_hit;
				s1_ctrl_span_ff <= ctrl_span;
				s1_ctrl_mgmt_ff <= ctrl_mgmt;
			end
		end
	end

	always @* begin
		nxt_span = resolve(s1_class_ff, s1_tag_span_valid_ff,
			s1_tag_span_ff, s1_learn_hit_ff, s1_learn_span_ff,
			s1_ctrl_hit_ff, s1_ctrl_span_ff, cfg_rsv_span,
			cfg_arp_span, cfg_igmp_span);
		nxt_mgmt = resolve(s1_class_ff, s1_tag_mgmt_valid_ff,
			s1_tag_mgmt_ff, s1_learn_hit_ff, s1_learn_mgmt_ff,
			s1_ctrl_hit_ff, s1_ctrl_mgmt_ff, cfg_rsv_mgmt,
			cfg_arp_mgmt, cfg_igmp_mgmt);
		// blocking and learning ports forward only span frames
		case (port_state)
		`FCS_STP_DISABLED: begin
			nxt_drop = 1'b1;
			nxt_learn = 1'b0;
		end
		`FCS_STP_BLOCKING: begin
			nxt_drop = !nxt_span;
			nxt_learn = 1'b0;
		end
		`FCS_STP_LEARNING: begin
			nxt_drop = !nxt_span;
			nxt_learn = 1'b1;
		end
		`FCS_STP_FORWARDING: begin
			nxt_drop = 1'b0;
			nxt_learn = 1'b1;
		end
		default: begin
			nxt_drop = 1'b1;
			nxt_learn = 1'b0;
		end
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			res_valid_ff <= 1'b0;
			res_class_ff <= `FCS_CLS_OTHER;
			res_group_ff <= `FCS_GRP_UNICAST;
			res_type_ff <= 1'b0;
			res_proto_ff <= 1'b0;
			res_l4_ff <= 1'b0;
			res_span_ff <= 1'b0;
			res_mgmt_ff <= 1'b0;
			res_exempt_ff <= 1'b0;
			res_drop_ff <= 1'b0;
			res_learn_ff <= 1'b0;
			res_state_ff <= `FCS_STP_RST;
		end else if (ce) begin
			res_valid_ff <= s1_valid_ff;
			if (s1_valid_ff) begin
				res_class_ff <= s1_class_ff;
				res_group_ff <= s1_group_ff;
				res_type_ff <= s1_type_ff;
				res_proto_ff <= s1_proto_ff;
				res_l4_ff <= s1_l4_ff;
				res_span_ff <= nxt_span;
				res_mgmt_ff <= nxt_mgmt;
				// queue logic uses this to bypass limiters and discard
				res_exempt_ff <= nxt_mgmt;
				res_drop_ff <= nxt_drop;
				res_learn_ff <= nxt_learn;
				res_state_ff <= port_state;
			end
		end
	end

	assign res_valid = res_valid_ff;
	assign res_class = res_class_ff;
	assign res_group = res_group_ff;
	assign res_type_match = res_type_ff;
	assign res_proto_match = res_proto_ff;
	assign l4_port_filter_match = res_l4_ff;
	assign res_span = res_span_ff;
	assign res_mgmt = res_mgmt_ff;
	assign res_mgmt_exempt = res_exempt_ff;
	assign res_fwd_drop = res_drop_ff;
	assign res_learn_en = res_learn_ff;
	assign res_port_state = res_state_ff;
endmodule // fcs_classifier

/* tb/fcs_checker.sv */
`timescale 1ns/1ps
module fcs_checker (
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire hdr_valid,
	input wire [47:0] dest_addr,
	input wire [15:0] ether_type,
	input wire [15:0] ctrl_opcode,
	input wire tag_span_valid,
	input wire tag_span,
	input wire tag_mgmt_valid,
	input wire tag_mgmt,
	input wire res_valid,
	input wire [3:0] res_class,
	input wire [1:0] res_group,
	input wire res_span,
	input wire res_mgmt,
	input wire res_mgmt_exempt
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// result of a header taken two enabled edges back
	sequence s_took;
		ce [*2] ##1 res_valid;
	endsequence
	property p_lat;
		ce [*2] |=> res_valid == $past(hdr_valid, 2);
	endproperty
	a_lat: assert property (p_lat) else $error("result latency");
	property p_hold;
		!res_valid |-> $stable({res_class, res_group, res_span, res_mgmt});
	endproperty
	a_hold: assert property (p_hold) else $error("result moved");
	property p_grp;
		s_took |-> res_group == (&$past(dest_addr, 2) ? 2'h2 :
			{1'b0, $past(dest_addr[40], 2)});
	endproperty
	a_grp: assert property (p_grp) else $error("address group");
	property p_bpdu;
		s_took ##0 $past(dest_addr == 48'h0180C2000000, 2) |-> res_class == 4'h1;
	endproperty
	a_bpdu: assert property (p_bpdu) else $error("bridge class");
	property p_pause;
		s_took ##0 $past(dest_addr == 48'h0180C2000001 &&
			ether_type == 16'h8808 && ctrl_opcode == 16'h0001, 2)
			|-> res_class == 4'h2;
	endproperty
	a_pause: assert property (p_pause) else $error("pause class");
	property p_arp;
		s_took ##0 $past(&dest_addr && ether_type == 16'h8036, 2)
			|-> res_class == 4'hB;
	endproperty
	a_arp: assert property (p_arp) else $error("arp class");
	property p_ctl;
		s_took ##0 $past(dest_addr[47:8] != 40'h0180C20000 &&
			ether_type == 16'h8808 && ctrl_opcode != 16'h0001, 2)
			|-> res_class == 4'hF;
	endproperty
	a_ctl: assert property (p_ctl) else $error("control class");
	property p_tsp;
		s_took ##0 $past(tag_span_valid, 2) |-> res_span == $past(tag_span, 2);
	endproperty
	a_tsp: assert property (p_tsp) else $error("tag span");
	property p_tmg;
		s_took ##0 $past(tag_mgmt_valid, 2) |-> res_mgmt == $past(tag_mgmt, 2);
	endproperty
	a_tmg: assert property (p_tmg) else $error("tag mgmt");
	property p_exm;
		res_mgmt_exempt == res_mgmt;
	endproperty
	a_exm: assert property (p_exm) else $error("exempt flag");
endmodule // fcs_checker

/* tb/fcs_fwd_model.sv */
`timescale 1ns/1ps
// forwarding side: takes each result once, even across stalls
module fcs_fwd_model (
	input wire clk,
	input wire ce,
	input wire res_valid,
	input wire res_fwd_drop,
	output integer n_rx,
	output integer n_fwd
);
	initial n_rx = 0;
	initial n_fwd = 0;
	always @(posedge clk) begin
		if (ce && res_valid) begin
			n_rx <= n_rx + 1;
			n_fwd <= n_fwd + !res_fwd_drop;
		end
	end
endmodule // fcs_fwd_model

/* tb/fcs_classifier_bench.sv */
`timescale 1ns/1ps
module fcs_classifier_bench;
	reg clk = 0, rstn = 0, ce = 1, hdr_valid = 0, stp_wr_en = 0, pce = 0;
	reg tag_span_valid, tag_span, tag_mgmt_valid, tag_mgmt, learn_hit;
	reg learn_span, learn_mgmt, ctrl_hit, ctrl_span, ctrl_mgmt;
	reg cfg_rsv_span, cfg_rsv_mgmt, cfg_arp_span, cfg_arp_mgmt;
	reg cfg_igmp_span, cfg_igmp_mgmt;
	reg cfg_type_flt_en, cfg_proto_flt_en, cfg_l4_flt_en;
	reg [47:0] dest_addr = 48'h0;
	reg [15:0] ether_type = 16'h0, ctrl_opcode = 16'h0, l4_port = 16'h0;
	reg [15:0] cfg_type_flt = 16'h88CC, cfg_l4_flt = 16'h0035;
	reg [7:0] ip_protocol = 8'h0, cfg_proto_flt = 8'h11;
	reg [3:0] ip_version = 4'h0;
	reg [2:0] src_port = 3'h0, stp_wr_port = 3'h0;
	reg [1:0] stp_wr_state = 2'h0;
	reg [1:0] st [0:5];
	reg [14:0] q [$];
	reg [14:0] x;
	reg [31:0] r = 32'h0;
	reg [127:0] lbs = 128'h00010203040F101F2022232F30FF0531;
	// indexed by address kind, lowest entry first
	reg [111:0] ets = 112'h8036_8808_88CC_0800_0800_8035_8808;
	wire res_valid, res_type_match, res_proto_match, l4_port_filter_match;
	wire res_span, res_mgmt, res_mgmt_exempt, res_fwd_drop, res_learn_en;
	wire [3:0] res_class;
	wire [1:0] res_group, res_port_state;
	integer seed = 32'h1950, num_errors = 0, cmp_count = 0, n_hdr = 0;
	integer i, j, k, n_rx, n_fwd, n_pass = 0;

	fcs_classifier uut (.clk, .rstn, .ce, .hdr_valid, .dest_addr, .ether_type,
		.ctrl_opcode, .ip_version, .ip_protocol, .l4_port, .src_port,
		.tag_span_valid, .tag_span, .tag_mgmt_valid, .tag_mgmt, .learn_hit,
		.learn_span, .learn_mgmt, .ctrl_hit, .ctrl_span, .ctrl_mgmt,
		.cfg_rsv_span, .cfg_rsv_mgmt, .cfg_arp_span, .cfg_arp_mgmt,
		.cfg_igmp_span, .cfg_igmp_mgmt, .cfg_type_flt_en, .cfg_type_flt,
		.cfg_proto_flt_en, .cfg_proto_flt, .cfg_l4_flt_en, .cfg_l4_flt,
		.stp_wr_en, .stp_wr_port, .stp_wr_state, .res_valid, .res_class,
		.res_group, .res_type_match, .res_proto_match, .l4_port_filter_match,
		.res_span, .res_mgmt, .res_mgmt_exempt, .res_fwd_drop, .res_learn_en,
		.res_port_state);
	fcs_fwd_model fwd (.clk, .ce, .res_valid, .res_fwd_drop, .n_rx, .n_fwd);

	initial forever #2.5 clk = ~clk;

	task chk(input [15:0] a, input [15:0] b);
		begin
			cmp_count = cmp_count + 1;
			if (a !== b) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: seen %h expected %h", $time, a, b);
			end
		end
	endtask

	function [3:0] ecls(input [47:0] d, input [15:0] e, o, input [3:0] v,
		input [7:0] p);
		reg [7:0] b;
		begin
			b = d[7:0];
			if (d[47:8] == 40'h0180C20000)
				ecls = b == 8'h00 ? 4'h1 : b == 8'h01 ?
					(e != 16'h8808 ? 4'h0 : o == 16'h0001 ? 4'h2 : 4'hF) :
					b == 8'h02 ? 4'h3 : b == 8'h03 ? 4'h4 : b < 8'h10 ? 4'h5 :
					b < 8'h20 ? 4'h6 : b < 8'h23 ? 4'h7 : b < 8'h30 ? 4'h8 : 4'h9;
			else if (&d && e == 16'h8035) ecls = 4'hA;
			else if (&d && e == 16'h8036) ecls = 4'hB;
			else if (d[47:24] == 24'h01005E && e == 16'h0800 && v == 4'h4 &&
				p == 8'h02) ecls = 4'hC;
			else if (d[47:32] == 16'h3333 && e == 16'h0800 && v == 4'h6 &&
				p == 8'h3A) ecls = 4'hD;
			else if (d[47:32] == 16'h3333 && e == 16'h86DD && v == 4'h6 &&
				p == 8'h3A) ecls = 4'hE;
			else if (e == 16'h8808 && o != 16'h0001) ecls = 4'hF;
			else ecls = 4'h0;
		end
	endfunction

	// one chain serves span and management alike
	function ech(input [3:0] c, input tv, tb, lh, lb, ch, cb, rs, a, g);
		if (tv) ech = tb;
		else if (c >= 4'h1 && c <= 4'h9 && c != 4'h2) ech = lh ? lb : ch ? cb : rs;
		else if (c == 4'hA || c == 4'hB) ech = a;
		else if (c >= 4'hC && c <= 4'hE) ech = g;
		else ech = lh & lb;
	endfunction

	task hdr(input [47:0] d, input [15:0] e);
		reg [3:0] c;
		reg s, m, dr;
		reg [1:0] p;
		begin
			@(negedge clk);
			dest_addr = d;
			ether_type = e;
			ctrl_opcode = $random(seed) & 3;
			ip_version = ($random(seed) & 1) ? 4'h4 : 4'h6;
			k = $random(seed) & 3;
			ip_protocol = k == 0 ? 8'h02 : k == 1 ? 8'h3A : k == 2 ? 8'h11 : r[7:0];
			l4_port = ($random(seed) & 1) ? 16'h0035 : r[31:16];
			src_port = {$random(seed)} % 6;
			{tag_span_valid, tag_span, tag_mgmt_valid, tag_mgmt, learn_hit,
				learn_span, learn_mgmt, ctrl_hit, ctrl_span, ctrl_mgmt,
				cfg_type_flt_en, cfg_proto_flt_en, cfg_l4_flt_en} = $random(seed);
			{stp_wr_port, stp_wr_state} = $random(seed);
			stp_wr_en = ($random(seed) & 3) == 0;
			ce = ($random(seed) & 7) != 0;
			hdr_valid = 1;
			c = ecls(d, e, ctrl_opcode, ip_version, ip_protocol);
			s = ech(c, tag_span_valid, tag_span, learn_hit, learn_span, ctrl_hit,
				ctrl_span, cfg_rsv_span, cfg_arp_span, cfg_igmp_span);
			m = ech(c, tag_mgmt_valid, tag_mgmt, learn_hit, learn_mgmt, ctrl_hit,
				ctrl_mgmt, cfg_rsv_mgmt, cfg_arp_mgmt, cfg_igmp_mgmt);
			p = st[src_port];
			dr = p == 2'h0 || (p != 2'h3 && !s);
			if (ce) begin
				n_hdr = n_hdr + 1;
				n_pass = n_pass + !dr;
				q.push_back({c, &d ? 2'h2 : {1'b0, d[40]},
					cfg_type_flt_en && e == cfg_type_flt,
					cfg_proto_flt_en && ip_protocol == cfg_proto_flt,
					cfg_l4_flt_en && l4_port == cfg_l4_flt, s, m,
					dr, p[1], p});
				// write lands after this header, so it sees the old state
				if (stp_wr_en && stp_wr_port < 3'h6) st[stp_wr_port] = stp_wr_state;
			end
		end
	endtask

	always @(posedge clk) pce <= ce;
	always @(negedge clk) begin
		if (rstn && res_valid && pce) begin
			x = q.size() ? q.pop_front() : 15'h7FFF;
			chk(res_class, x[14:11]);
			chk(res_group, x[10:9]);
			chk({res_type_match, res_proto_match, l4_port_filter_match}, x[8:6]);
			chk({res_span, res_mgmt}, x[5:4]);
			chk(res_mgmt_exempt, x[4]);
			chk({res_fwd_drop, res_learn_en, res_port_state}, x[3:0]);
		end
	end

	task complete_run;
		begin
			$display("compares %0d mismatches %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0) $display("No errors found");
			else $display("Errors were found");
			$finish;
		end
	endtask

	initial begin
		for (i = 0; i < 6; i = i + 1) st[i] = 2'h3;
		repeat (12) @(negedge clk);
		rstn = 1;
		chk(res_port_state, 2'h3);
		for (j = 0; j < 2; j = j + 1) begin
			{cfg_rsv_span, cfg_rsv_mgmt, cfg_arp_span, cfg_arp_mgmt,
				cfg_igmp_span, cfg_igmp_mgmt} = $random(seed);
			// range edges first, then random traffic
			for (i = 0; i < 16; i = i + 1)
				hdr({40'h0180C20000, lbs[i * 8 +: 8]}, 16'h8808);
			for (i = 0; i < 400; i = i + 1) begin
				r = $random(seed);
				k = $random(seed) & 7;
				hdr(k == 0 ? {40'h0180C20000, r[7:0]} : k == 1 ? 48'hFFFFFFFFFFFF :
					k == 2 ? {24'h01005E, r[23:0]} : k == 3 ? {16'h3333, r} :
					{r[15:0], r}, k == 1 && r[8] ? 16'h8036 :
					k == 3 && r[8] ? 16'h86DD :
					k < 7 ? ets[k * 16 +: 16] : r[31:16]);
			end
			@(negedge clk);
			hdr_valid = 0;
			stp_wr_en = 0;
			ce = 1;
			for (i = 0; i < 20 && q.size() != 0; i = i + 1) @(negedge clk);
			// the forwarding side counts the last result one edge later
			repeat (2) @(negedge clk);
			chk(q.size(), 16'h0);
			$display("phase %0d done", j);
		end
		chk(n_rx, n_hdr);
		chk(n_fwd, n_pass);
		complete_run;
	end
endmodule // fcs_classifier_bench

bind fcs_classifier fcs_checker u_chk (.clk, .rstn, .ce, .hdr_valid,
	.dest_addr, .ether_type, .ctrl_opcode, .tag_span_valid, .tag_span,
	.tag_mgmt_valid, .tag_mgmt, .res_valid, .res_class, .res_group,
	.res_span, .res_mgmt, .res_mgmt_exempt);
